/* hw/tecc_pkg.sv */
// Constants, types and register map of the event-count/capture timer.
// Assumes one 40 MHz clock and a plain strobe register port.
// Function
// - Mode bits: 101 PWM toggle, 100 PWM, 000/001 event count, rest capture.
// - Event mode counts synchronized pin A edges; 000 rising, 001 falling.
// - Event mode sets pending A on underflow; interrupt needs enable A.
// - Event mode latches pin B rising edges into pending B, gated by enable B.
// - No toggle output in event mode; pin A is the count input.
// - Capture mode counts continuously at slow or fast rate.
// - Capture mode copies timer into capture A or B on pin edges.
// - Capture edges per pin: 010 rr, 110 rf, 011 fr, 111 ff.
// - Capture triggers set pending A or B, each gated by its enable.
// - Capture mode latches underflow into run bit; shares interrupt A.
// - In PWM and event modes the run bit starts and stops the timer.
// - Enable flag 1 permits its interrupt, 0 blocks it.
// - Capture registers readable anytime without disturbing the count.
// - Control register accepts any access safely in every mode.
// - PWM reloads from A on first underflow, then alternately B and A.
// - PWM underflows set pending A or B matching the reload source.
// - High-speed select 1 counts on fast clock, 0 slow; reset clears it.
// - Pending flags stay set until software clears them.
package tecc_pkg;
  // Register offsets
  localparam logic [3:0] TECC_CTRL_OFS  = 4'h0;
  localparam logic [3:0] TECC_TLO_OFS   = 4'h1;
  localparam logic [3:0] TECC_THI_OFS   = 4'h2;
  localparam logic [3:0] TECC_RALO_OFS  = 4'h3;
  localparam logic [3:0] TECC_RAHI_OFS  = 4'h4;
  localparam logic [3:0] TECC_RBLO_OFS  = 4'h5;
  localparam logic [3:0] TECC_RBHI_OFS  = 4'h6;
  localparam logic [3:0] TECC_HSTC_OFS  = 4'h7;
  // Control register fields, then the high-speed select bit
  localparam int TECC_RUN_BIT  = 0;
  localparam int TECC_MODE_LSB = 1;
  localparam int TECC_PNDA_BIT = 4;
  localparam int TECC_ENA_BIT  = 5;
  localparam int TECC_PNDB_BIT = 6;
  localparam int TECC_ENB_BIT  = 7;
  localparam int TECC_HS_BIT   = 0;
  // Reset values
  localparam logic [7:0]  TECC_CTRL_RST  = 8'h00;
  localparam logic [15:0] TECC_WORD_RST  = 16'h0000;
  localparam logic        TECC_HS_RST    = 1'b0;
  // Slow tick period in clock cycles (instruction cycle)
  localparam int TECC_SLOW_DIV = 10;
  // Mode codes {bit2,bit1,bit0}
  localparam logic [2:0] TECC_M_PWM_TGL = 3'h5;
  localparam logic [2:0] TECC_M_PWM     = 3'h4;
  localparam logic [2:0] TECC_M_EVT_R   = 3'h0;
  localparam logic [2:0] TECC_M_EVT_F   = 3'h1;

  typedef enum logic [2:0] {
    TECC_PWM_ST = 3'b001,
    TECC_EVT_ST = 3'b010,
    TECC_CAP_ST = 3'b100
  } tecc_mode_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tecc_bus_type;
endpackage

/* hw/tecc_timer.sv */
// Event-count / capture / PWM timer with byte register port.
// Assumes pins are synchronous to clk_in; read data one cycle after strobe.
`timescale 1ns/1ps
module tecc_timer
  import tecc_pkg::*;
#(
  parameter int SLOW_DIV = TECC_SLOW_DIV
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       timer_pin_a_in,
  input  wire logic       timer_pin_b_in,
  output logic      [7:0] rdata_out,
  output logic            irq_a_out,
  output logic            irq_b_out,
  output logic            timer_pin_a_out,
  output logic            timer_pin_a_oe_out
);

  tecc_bus_type  bus;
  tecc_mode_type mode;
  logic [7:0]  ctrl_r;
  logic        hs_r;
  logic [15:0] cnt_r;
  logic [15:0] rca_r;
  logic [15:0] rcb_r;
  logic        nxt_b_r;
  logic        tgl_r;
  logic [1:0]  a_sync_r;
  logic [1:0]  b_sync_r;
  logic        a_prev_r;
  logic        b_prev_r;
  logic [$clog2(SLOW_DIV)-1:0] div_r;
  logic        slow_tick;
  logic        tick;
  logic        run;
  logic        uflow;
  logic        a_rise;
  logic        a_fall;
  logic        b_rise;
  logic        b_fall;
  logic        trig_a;
  logic        trig_b;
  logic        wr_ctrl;
  logic [2:0]  msel;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign msel = ctrl_r[TECC_MODE_LSB+2:TECC_MODE_LSB];
  assign wr_ctrl = bus.wr && bus.addr == TECC_CTRL_OFS;

  //////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb begin
    case (msel)
      TECC_M_PWM_TGL, TECC_M_PWM: mode = TECC_PWM_ST;
      TECC_M_EVT_R, TECC_M_EVT_F: mode = TECC_EVT_ST;
      default:                    mode = TECC_CAP_ST;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Slow instruction-cycle tick divider
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_r <= '0;
    end else if (ce_in) begin
      if (div_r == ($clog2(SLOW_DIV))'(SLOW_DIV - 1)) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end
  assign slow_tick = div_r == ($clog2(SLOW_DIV))'(SLOW_DIV - 1);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, sampled at the selected rate
  // Sampling only on the selected tick keeps edges aligned to the count rate
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      a_sync_r <= 2'h0;
      b_sync_r <= 2'h0;
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
    end else if (ce_in && (hs_r || slow_tick)) begin
      a_sync_r <= {a_sync_r[0], timer_pin_a_in};
      b_sync_r <= {b_sync_r[0], timer_pin_b_in};
      a_prev_r <= a_sync_r[1];
      b_prev_r <= b_sync_r[1];
    end
  end
  always_comb begin
    a_rise = a_sync_r[1] && !a_prev_r && (hs_r || slow_tick);
    a_fall = !a_sync_r[1] && a_prev_r && (hs_r || slow_tick);
    b_rise = b_sync_r[1] && !b_prev_r && (hs_r || slow_tick);
    b_fall = !b_sync_r[1] && b_prev_r && (hs_r || slow_tick);
    trig_a = msel[0] ? a_fall : a_rise;
    trig_b = msel[2] ? b_fall : b_rise;
  end

  //////////////////////////////////////////////////////////////////////////
  // Count tick selection
  always_comb begin
    run = ctrl_r[TECC_RUN_BIT];
    case (mode)
      TECC_PWM_ST: tick = run && (hs_r || slow_tick);
      TECC_EVT_ST: tick = run && (msel[0] ? a_fall : a_rise);
      TECC_CAP_ST: tick = hs_r || slow_tick;
      default:     tick = 1'b0;
    endcase
    uflow = tick && cnt_r == 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////
  // Timer counter and PWM reload sequence
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r   <= TECC_WORD_RST;
      nxt_b_r <= 1'b0;
      tgl_r   <= 1'b0;
    end else if (ce_in) begin
      if (bus.wr && bus.addr == TECC_TLO_OFS) begin
        cnt_r[7:0] <= bus.wdata;
      end else if (bus.wr && bus.addr == TECC_THI_OFS) begin
        cnt_r[15:8] <= bus.wdata;
      end else if (uflow && mode == TECC_PWM_ST) begin
        cnt_r   <= nxt_b_r ? rcb_r : rca_r;
        nxt_b_r <= !nxt_b_r;
        tgl_r   <= msel == TECC_M_PWM_TGL ? !tgl_r : tgl_r;
      end else if (tick) begin
        cnt_r <= cnt_r - 16'h0001;
      end
      if (mode != TECC_PWM_ST) begin
        nxt_b_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reload / capture registers; reads never touch the count
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rca_r <= TECC_WORD_RST;
      rcb_r <= TECC_WORD_RST;
    end else if (ce_in) begin
      if (mode == TECC_CAP_ST && trig_a) begin
        rca_r <= cnt_r;
      end else if (bus.wr && bus.addr == TECC_RALO_OFS) begin
        rca_r[7:0] <= bus.wdata;
      end else if (bus.wr && bus.addr == TECC_RAHI_OFS) begin
        rca_r[15:8] <= bus.wdata;
      end
      if (mode == TECC_CAP_ST && trig_b) begin
        rcb_r <= cnt_r;
      end else if (bus.wr && bus.addr == TECC_RBLO_OFS) begin
        rcb_r[7:0] <= bus.wdata;
      end else if (bus.wr && bus.addr == TECC_RBHI_OFS) begin
        rcb_r[15:8] <= bus.wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control register: events set over software clears
  // Writes land safely in any mode since events simply OR in after them
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r <= TECC_CTRL_RST;
    end else if (ce_in) begin
      ctrl_r <= wr_ctrl ? bus.wdata : ctrl_r;
      case (mode)
        TECC_PWM_ST: begin
          if (uflow && !nxt_b_r) begin
            ctrl_r[TECC_PNDA_BIT] <= 1'b1;
          end
          if (uflow && nxt_b_r) begin
            ctrl_r[TECC_PNDB_BIT] <= 1'b1;
          end
        end
        TECC_EVT_ST: begin
          if (uflow) begin
            ctrl_r[TECC_PNDA_BIT] <= 1'b1;
          end
          if (b_rise) begin
            ctrl_r[TECC_PNDB_BIT] <= 1'b1;
          end
        end
        TECC_CAP_ST: begin
          if (trig_a) begin
            ctrl_r[TECC_PNDA_BIT] <= 1'b1;
          end
          if (trig_b) begin
            ctrl_r[TECC_PNDB_BIT] <= 1'b1;
          end
          if (uflow) begin
            ctrl_r[TECC_RUN_BIT] <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end
  // Pending flags only fall on a software write

  //////////////////////////////////////////////////////////////////////////
  // High-speed select
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hs_r <= TECC_HS_RST;
    end else if (ce_in && bus.wr && bus.addr == TECC_HSTC_OFS) begin
      hs_r <= bus.wdata[TECC_HS_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      rdata_out <= 8'h00;
      if (bus.rd) begin
        case (bus.addr)
          TECC_CTRL_OFS: rdata_out <= ctrl_r;
          TECC_TLO_OFS:  rdata_out <= cnt_r[7:0];
          TECC_THI_OFS:  rdata_out <= cnt_r[15:8];
          TECC_RALO_OFS: rdata_out <= rca_r[7:0];
          TECC_RAHI_OFS: rdata_out <= rca_r[15:8];
          TECC_RBLO_OFS: rdata_out <= rcb_r[7:0];
          TECC_RBHI_OFS: rdata_out <= rcb_r[15:8];
          TECC_HSTC_OFS: rdata_out <= {7'h00, hs_r};
          default:       rdata_out <= 8'h00;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt requests and pin A drive
  always_comb begin
    irq_a_out = ctrl_r[TECC_ENA_BIT] && (ctrl_r[TECC_PNDA_BIT] ||
                (mode == TECC_CAP_ST && ctrl_r[TECC_RUN_BIT]));
    irq_b_out = ctrl_r[TECC_ENB_BIT] && ctrl_r[TECC_PNDB_BIT];
    timer_pin_a_out    = tgl_r;
    timer_pin_a_oe_out = msel == TECC_M_PWM_TGL;
  end

endmodule

/* testbench/tecc_pin_model.sv */
// Outside signals on the two timer pins.
// Assumes each call starts just after a rising edge.
`timescale 1ns/1ps
module tecc_pin_model (
  input  wire logic clk_in,
  output logic      pin_a_out,
  output logic      pin_b_out
);
  ////////////////////////////////////////
  // Pins idle low; short pulses may be missed, so levels are held
  initial begin
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
  end
  // Move the selected pins, then hold for n cycles
  task automatic drive(input logic [1:0] sel, input logic lvl, input int n);
    if (sel[0]) pin_a_out <= lvl;
    if (sel[1]) pin_b_out <= lvl;
    repeat (n) @(posedge clk_in);
  endtask
endmodule

/* testbench/tecc_timer_sva.sv */
// Port assertions for the timer.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
module tecc_timer_sva
  import tecc_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       ce_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic       timer_pin_a_in,
  input wire logic       timer_pin_b_in,
  input wire logic [7:0] rdata_out,
  input wire logic       irq_a_out,
  input wire logic       irq_b_out,
  input wire logic       timer_pin_a_out,
  input wire logic       timer_pin_a_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic ctl_wr;
  // Control write taken this cycle
  assign ctl_wr = wr_in && ce_in && addr_in == TECC_CTRL_OFS;
  ////////////////////////////////////////
  rd_idle_a:
  assert property (ce_in && !rd_in |=> rdata_out == 8'h00)
    else $error("stray read data");
  tgl_oe_a:
  assert property (ctl_wr && wdata_in[3:1] == TECC_M_PWM_TGL
    |=> timer_pin_a_oe_out) else $error("toggle not driven");
  evt_no_oe_a:
  assert property (ctl_wr && wdata_in[3:2] == 2'h0
    |=> !timer_pin_a_oe_out) else $error("pin driven in event");
  oe_hold_a:
  assert property (!ctl_wr |=> $stable(timer_pin_a_oe_out))
    else $error("enable moved");
  ena_off_a:
  assert property (ctl_wr && !wdata_in[TECC_ENA_BIT] |=> !irq_a_out)
    else $error("irq a unmasked");
  enb_off_a:
  assert property (ctl_wr && !wdata_in[TECC_ENB_BIT] |=> !irq_b_out)
    else $error("irq b unmasked");
  pend_irq_a:
  assert property (ctl_wr && wdata_in[7:4] == 4'hF
    |=> irq_a_out && irq_b_out) else $error("irq missing");
  pndb_hold_a:
  assert property (irq_b_out && !ctl_wr |=> irq_b_out)
    else $error("pending b lost");
endmodule
bind tecc_timer tecc_timer_sva u_sva (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .timer_pin_a_in(timer_pin_a_in), .timer_pin_b_in(timer_pin_b_in),
  .rdata_out(rdata_out), .irq_a_out(irq_a_out), .irq_b_out(irq_b_out),
  .timer_pin_a_out(timer_pin_a_out),
  .timer_pin_a_oe_out(timer_pin_a_oe_out));

/* testbench/testbench.sv */
// Self-checking bench for the timer.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module testbench
  import tecc_pkg::*;
;
  typedef struct packed {
    logic [2:0]  m;
    logic        hs;
    logic [1:0]  p;
    logic [15:0] df;
  } tecc_row_type;
  // Capture code, fast select, pending B/A after rise, A minus B
  tecc_row_type rows [5] = '{'{3'h2, 1'h1, 2'h3, 16'h0000},
    '{3'h6, 1'h1, 2'h1, 16'h000C}, '{3'h3, 1'h1, 2'h2, 16'hFFF4},
    '{3'h7, 1'h1, 2'h0, 16'h0000}, '{3'h6, 1'h0, 2'h1, 16'h0006}};
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [3:0]  addr_in = 4'h0;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        pin_a, pin_b, irq_a, irq_b, pa_oe, pa_out;
  logic [7:0]  rdata, d;
  logic [15:0] va, vb;
  int          err_total = 0;
  int          tests_run = 0;
  ////////////////////////////////////////
  always #12.5 clk_in = ~clk_in;
  tecc_pin_model u_pins (.clk_in(clk_in), .pin_a_out(pin_a),
    .pin_b_out(pin_b));
  tecc_timer #(.SLOW_DIV(2)) u_tecc_timer (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .timer_pin_a_in(pin_a), .timer_pin_b_in(pin_b), .rdata_out(rdata),
    .irq_a_out(irq_a), .irq_b_out(irq_b), .timer_pin_a_out(pa_out),
    .timer_pin_a_oe_out(pa_oe));
  // One-cycle strobes; an idle edge follows so strobes never re-assert
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata;
    @(posedge clk_in);
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 4'h1, v[15:8]);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk_in);
    err_total++;
    conclude();
  end
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    // Capture pairs: equal polarity gives equal values
    wr(TECC_HSTC_OFS, 8'h01);
    foreach (rows[i]) begin
      wr(TECC_HSTC_OFS, {7'h00, rows[i].hs});
      wr(TECC_CTRL_OFS, {4'h0, rows[i].m, 1'b0});
      u_pins.drive(2'h3, 1'b1, 10);
      rd(TECC_CTRL_OFS, d);
      `CHK({d[6], d[4]}, rows[i].p)
      u_pins.drive(2'h3, 1'b0, 10);
      rd16(TECC_RALO_OFS, va);
      rd16(TECC_RBLO_OFS, vb);
      `CHK(va - vb, rows[i].df)
    end
    $display("capture test done");
    // Reset state, an unmapped hole, full control readback
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(TECC_CTRL_OFS, d);
    `CHK(d, TECC_CTRL_RST)
    rd(TECC_HSTC_OFS, d);
    `CHK(d[0], TECC_HS_RST)
    rd(4'hF, d);
    `CHK(d, 8'h00)
    wr(TECC_CTRL_OFS, 8'hF0);
    rd(TECC_CTRL_OFS, d);
    `CHK(d, 8'hF0)
    // Capture counts with run clear; first underflow lands in run bit
    wr(TECC_HSTC_OFS, 8'h01);
    wr(TECC_CTRL_OFS, 8'h24);
    repeat (4) @(posedge clk_in);
    rd(TECC_CTRL_OFS, d);
    `CHK(d[0], 1'b1)
    `CHK(irq_a, 1'b1)
    wr(TECC_CTRL_OFS, 8'h24);
    `CHK(irq_a, 1'b0)
    $display("reset test done");
    // Event counting on either edge, from count 2 down through zero
    for (int m = 0; m < 2; m++) begin
      wr(TECC_CTRL_OFS, {4'hA, 3'(m), 1'b0});
      wr16(TECC_TLO_OFS, 16'h0002);
      wr(TECC_CTRL_OFS, {4'hA, 3'(m), 1'b1});
      repeat (2) begin
        u_pins.drive(2'h3, 1'b1, 8);
        u_pins.drive(2'h3, 1'b0, 8);
      end
      `CHK(irq_a, 1'b0)
      `CHK(irq_b, 1'b1)
      u_pins.drive(2'h1, 1'b1, 8);
      `CHK(irq_a, m == 0)
      u_pins.drive(2'h1, 1'b0, 8);
      `CHK(irq_a, 1'b1)
      rd16(TECC_TLO_OFS, va);
      `CHK(va, 16'hFFFF)
      wr(TECC_CTRL_OFS, {4'hA, 3'(m), 1'b0});
      u_pins.drive(2'h1, 1'b1, 8);
      u_pins.drive(2'h1, 1'b0, 8);
      rd16(TECC_TLO_OFS, va);
      `CHK(va, 16'hFFFF)
    end
    // Clock enable low freezes synchronisers and count; edge then counts
    wr(TECC_CTRL_OFS, 8'h01);
    ce_in <= 1'b0;
    u_pins.drive(2'h1, 1'b1, 8);
    u_pins.drive(2'h1, 1'b0, 8);
    ce_in <= 1'b1;
    rd16(TECC_TLO_OFS, va);
    `CHK(va, 16'hFFFF)
    u_pins.drive(2'h1, 1'b1, 8);
    u_pins.drive(2'h1, 1'b0, 8);
    rd16(TECC_TLO_OFS, va);
    `CHK(va, 16'hFFFE)
    $display("event test done");
    // PWM: first reload from A, the next from B
    for (int m = 4; m < 6; m++) begin
      // Stop before touching reload or timer bytes in fast mode
      wr(TECC_CTRL_OFS, {4'h0, 3'(m), 1'b0});
      wr(TECC_HSTC_OFS, 8'h01);
      wr16(TECC_RALO_OFS, 16'h0028);
      wr16(TECC_RBLO_OFS, 16'h0028);
      wr16(TECC_TLO_OFS, 16'h0003);
      wr(TECC_CTRL_OFS, {4'h0, 3'(m), 1'b1});
      repeat (8) @(posedge clk_in);
      rd(TECC_CTRL_OFS, d);
      `CHK({d[6], d[4]}, 2'h1)
      `CHK(pa_out, m == 5)
      repeat (45) @(posedge clk_in);
      rd(TECC_CTRL_OFS, d);
      `CHK({d[6], d[4]}, 2'h3)
      `CHK(pa_oe, m == 5)
    end
    $display("pwm test done");
    conclude();
  end
endmodule
